// File: inc/scm_consts.svh
// Purpose: named offsets, field positions and reset values of the system-control block
// Assumes: byte addresses on a 32-bit register port, one word per register
// Notes:   definitions only
`ifndef SCM_CONSTS_SVH
`define SCM_CONSTS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define SCM_OFS_BLOCK_RESET_2   8'h0c
`define SCM_OFS_TEMP_CTRL       8'h20
`define SCM_OFS_PA_LOW_FUNC     8'h30
`define SCM_OFS_PA_HIGH_FUNC    8'h34
`define SCM_OFS_PB_LOW_FUNC     8'h38

// ****************************************************************
// reset values and writable masks
// ****************************************************************
`define SCM_RST_VALUE           32'h0000_0000
`define SCM_BLOCK_RESET_2_MASK  32'hd453_333e
`define SCM_TEMP_CTRL_MASK      32'h0000_0001
`define SCM_READ_ZERO           32'h0000_0000

// ****************************************************************
// block reset and sensor enable bit positions
// ****************************************************************
`define SCM_BIT_CARD_IF1        31
`define SCM_BIT_CARD_IF0        30
`define SCM_BIT_ADC             28
`define SCM_BIT_SEGMENT_DISP    26
`define SCM_BIT_COMPARATOR      22
`define SCM_BIT_PULSE_WIDTH     20
`define SCM_BIT_SERIAL1         17
`define SCM_BIT_SERIAL0         16
`define SCM_BIT_SYNC_SERIAL1    13
`define SCM_BIT_SYNC_SERIAL0    12
`define SCM_BIT_TWO_WIRE1       9
`define SCM_BIT_TWO_WIRE0       8
`define SCM_BIT_TIMER_HI        5
`define SCM_BIT_TIMER_LO        2
`define SCM_BIT_GPIO            1
`define SCM_BIT_TEMP_ENABLE     0

// ****************************************************************
// function codes
// ****************************************************************
`define SCM_FN_GPIO             4'h0
`define SCM_FN_1                4'h1
`define SCM_FN_2                4'h2
`define SCM_FN_3                4'h3
`define SCM_FN_4                4'h4
`define SCM_FN_5                4'h5
`define SCM_FN_6                4'h6
`define SCM_FN_7                4'h7
`define SCM_FN_8                4'h8
`define SCM_FN_9                4'h9
`define SCM_FN_WIDTH            4
`define SCM_PINS_PER_REG        8

`endif

// File: inc/scm_pkg.sv
// Purpose: shared types of the system-control block
// Assumes: constants come from scm_consts.svh
// Notes:   types only
package scm_pkg;
  typedef logic [3:0]  scm_func_t;   // one pin function code
  typedef logic [31:0] scm_word_t;   // register word
  typedef logic [7:0]  scm_addr_t;   // byte address
endpackage

// File: design/scm_sys_ctrl.sv
// Purpose: peripheral block resets, temperature sensor enable and pin function select
// Assumes: one 100 MHz clock, synchronous active-high reset, plain register port
// Notes:   per-pin one-hot selects tell the pad ring which signal owns each of the twelve decoded pins
// Notes:   raw codes read back as written
// Notes:   outputs lag a write by one edge
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "scm_consts.svh"

module scm_sys_ctrl #(
  parameter int PORT_A_PINS = 16,  // pins of port a served here
  parameter int PORT_B_PINS = 8    // pins of port b served here
) (
  input  wire logic              clock_i,                  // system clock
  input  wire logic              rst_i,                    // synchronous reset
  input  wire scm_pkg::scm_addr_t addr_i,                  // register byte address
  input  wire scm_pkg::scm_word_t wdata_i,                 // write data
  input  wire logic              wr_i,                     // write strobe
  input  wire logic              rd_i,                     // read strobe
  output logic [31:0]            rdata_o,                  // read data, cycle after rd_i
  output logic                   card_if1_block_reset_o,   // card interface 1 reset
  output logic                   card_if0_block_reset_o,   // card interface 0 reset
  output logic                   adc_block_reset_o,        // analog converter reset
  output logic                   segment_display_block_reset_o, // segment display reset
  output logic                   comparator_block_reset_o, // comparator reset
  output logic                   pulse_width_block_reset_o, // pulse width reset
  output logic                   serial_port1_block_reset_o, // serial port 1 reset
  output logic                   serial_port0_block_reset_o, // serial port 0 reset
  output logic                   sync_serial1_block_reset_o, // sync serial 1 reset
  output logic                   sync_serial0_block_reset_o, // sync serial 0 reset
  output logic                   two_wire1_block_reset_o,  // two wire 1 reset
  output logic                   two_wire0_block_reset_o,  // two wire 0 reset
  output logic [3:0]             timer_block_reset_o,      // timers 3..0 reset
  output logic                   gpio_block_reset_o,       // gpio controller reset
  output logic                   temp_sensor_enable_o,     // temperature sensor on
  output logic [63:0]            port_a_function_o,        // port a codes, 4 bits per pin
  output logic [31:0]            port_b_function_o,        // port b low byte codes
  output logic [9:0]             pa1_select_o,             // pin a1 one-hot functions
  output logic [9:0]             pa2_select_o,             // pin a2 one-hot functions
  output logic [9:0]             pa5_select_o,             // pin a5 one-hot functions
  output logic [9:0]             pa8_select_o,             // pin a8 one-hot functions
  output logic [9:0]             pa11_select_o,            // pin a11 one-hot functions
  output logic [9:0]             pa12_select_o,            // pin a12 one-hot functions
  output logic [9:0]             pa13_select_o,            // pin a13 one-hot functions
  output logic [9:0]             pa14_select_o,            // pin a14 one-hot functions
  output logic [9:0]             pa15_select_o,            // pin a15 one-hot functions
  output logic [9:0]             pb5_select_o,             // pin b5 one-hot functions
  output logic [9:0]             pb6_select_o,             // pin b6 one-hot functions
  output logic [9:0]             pb7_select_o,             // pin b7 one-hot functions
  output logic                   serial0_tx_modulate_o,    // pin a12 carries modulable tx
  output logic                   serial1_tx_modulate_o     // pin b6 carries modulable tx
);
  import scm_pkg::*;

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  // pin tables are fixed
  if (PORT_A_PINS != 16 || PORT_B_PINS != 8) begin : g_bad_width
    $error("scm_sys_ctrl serves exactly 16 port a and 8 port b pins");
  end

  // ****************************************************************
  // functions
  // ****************************************************************
  // one-hot of a code, kept only where the code is listed for the pin
  // shared by every decoded pin
  function automatic logic [9:0] sel_decode(input scm_func_t code, input logic [9:0] legal);
    logic [9:0] hot;
    // start from nothing
    hot = 10'h000;
    // codes above nine are unlisted
    if (code <= `SCM_FN_9) begin
      hot[code] = 1'b1;
    end
    // unlisted codes fall back to gpio
    if ((hot & legal) == 10'h000) begin
      sel_decode = 10'h001;
    end else begin
      // listed code kept
      sel_decode = hot;
    end
  endfunction

  // code of pin n inside a register word
  // pin 0 sits in the low nibble
  function automatic scm_func_t pin_code(input scm_word_t word, input int n);
    pin_code = word[n*`SCM_FN_WIDTH +: `SCM_FN_WIDTH];
  endfunction

  // ****************************************************************
  // registers
  // ****************************************************************
  // software writes, reset clears
  scm_word_t block_reset_2;           // peripheral block reset levels
  scm_word_t temp_sensor_control;     // temperature sensor control
  scm_word_t port_a_low_pin_function; // port a pins 0-7 codes
  scm_word_t port_a_high_pin_function; // port a pins 8-15 codes
  scm_word_t port_b_low_pin_function; // port b pins 0-7 codes

  // address decode
  // exact match, no aliases
  // unmapped hits nothing
  wire logic hit_reset = (addr_i == `SCM_OFS_BLOCK_RESET_2);
  wire logic hit_temp  = (addr_i == `SCM_OFS_TEMP_CTRL);
  wire logic hit_pal   = (addr_i == `SCM_OFS_PA_LOW_FUNC);
  wire logic hit_pah   = (addr_i == `SCM_OFS_PA_HIGH_FUNC);
  wire logic hit_pbl   = (addr_i == `SCM_OFS_PB_LOW_FUNC);

  // reserved bits masked off on write
  // pin words have no reserved bits
  wire scm_word_t next_block_reset_2 = wdata_i & `SCM_BLOCK_RESET_2_MASK;
  wire scm_word_t next_temp_ctrl     = wdata_i & `SCM_TEMP_CTRL_MASK;

  // read mux, unmapped addresses read zero
  // decodes never overlap
  wire scm_word_t next_rdata =
    hit_reset ? block_reset_2 :
    hit_temp  ? temp_sensor_control :
    hit_pal   ? port_a_low_pin_function :
    hit_pah   ? port_a_high_pin_function :
    hit_pbl   ? port_b_low_pin_function : `SCM_READ_ZERO;

  // ****************************************************************
  // register writes
  // ****************************************************************
  // reset levels stay until software clears them
  // reserved bits stay zero
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      // all peripherals run
      block_reset_2 <= `SCM_RST_VALUE;
    end else if (wr_i && hit_reset) begin
      // level held until cleared
      block_reset_2 <= next_block_reset_2;
    end
  end

  // temperature control
  // one enable bit
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      // sensor off
      temp_sensor_control <= `SCM_RST_VALUE;
    end else if (wr_i && hit_temp) begin
      // only bit zero kept
      temp_sensor_control <= next_temp_ctrl;
    end
  end

  // pin function registers, every bit is a code bit
  // stored raw, even unlisted
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      // every pin gpio
      port_a_low_pin_function  <= `SCM_RST_VALUE;
      port_a_high_pin_function <= `SCM_RST_VALUE;
      port_b_low_pin_function  <= `SCM_RST_VALUE;
    end else if (wr_i) begin
      // port a pins 0-7
      if (hit_pal) begin
        port_a_low_pin_function <= wdata_i;
      end
      // port a pins 8-15
      if (hit_pah) begin
        port_a_high_pin_function <= wdata_i;
      end
      // port b pins 0-7
      if (hit_pbl) begin
        port_b_low_pin_function <= wdata_i;
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      // port cleared
      rdata_o <= `SCM_READ_ZERO;
    end else if (rd_i) begin
      // no wait state
      rdata_o <= next_rdata;
    end else begin
      // idle bus reads zero
      rdata_o <= `SCM_READ_ZERO;
    end
  end

  // ****************************************************************
  // reset and enable outputs
  // ****************************************************************
  // registered copies, so outputs come straight from flops
  // keeps glitches off reset lines
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      // nothing held in reset
      card_if1_block_reset_o        <= 1'b0;
      card_if0_block_reset_o        <= 1'b0;
      adc_block_reset_o             <= 1'b0;
      segment_display_block_reset_o <= 1'b0;
      comparator_block_reset_o      <= 1'b0;
      pulse_width_block_reset_o     <= 1'b0;
      serial_port1_block_reset_o    <= 1'b0;
      serial_port0_block_reset_o    <= 1'b0;
      sync_serial1_block_reset_o    <= 1'b0;
      sync_serial0_block_reset_o    <= 1'b0;
      two_wire1_block_reset_o       <= 1'b0;
      two_wire0_block_reset_o       <= 1'b0;
      timer_block_reset_o           <= 4'h0;
      gpio_block_reset_o            <= 1'b0;
      temp_sensor_enable_o          <= 1'b0;
    end else begin
      // copy register bits
      card_if1_block_reset_o        <= block_reset_2[`SCM_BIT_CARD_IF1];
      card_if0_block_reset_o        <= block_reset_2[`SCM_BIT_CARD_IF0];
      adc_block_reset_o             <= block_reset_2[`SCM_BIT_ADC];
      segment_display_block_reset_o <= block_reset_2[`SCM_BIT_SEGMENT_DISP];
      comparator_block_reset_o      <= block_reset_2[`SCM_BIT_COMPARATOR];
      pulse_width_block_reset_o     <= block_reset_2[`SCM_BIT_PULSE_WIDTH];
      serial_port1_block_reset_o    <= block_reset_2[`SCM_BIT_SERIAL1];
      serial_port0_block_reset_o    <= block_reset_2[`SCM_BIT_SERIAL0];
      sync_serial1_block_reset_o    <= block_reset_2[`SCM_BIT_SYNC_SERIAL1];
      sync_serial0_block_reset_o    <= block_reset_2[`SCM_BIT_SYNC_SERIAL0];
      two_wire1_block_reset_o       <= block_reset_2[`SCM_BIT_TWO_WIRE1];
      two_wire0_block_reset_o       <= block_reset_2[`SCM_BIT_TWO_WIRE0];
      // one field, four timers
      timer_block_reset_o <= block_reset_2[`SCM_BIT_TIMER_HI:`SCM_BIT_TIMER_LO];
      gpio_block_reset_o            <= block_reset_2[`SCM_BIT_GPIO];
      // sensor enable bit
      temp_sensor_enable_o <= temp_sensor_control[`SCM_BIT_TEMP_ENABLE];
    end
  end

  // ****************************************************************
  // pin function decode
  // ****************************************************************
  // legal code sets per pin, bit n set when code n is listed
  // port a
  localparam logic [9:0] LEGAL_PA1  = 10'h20d; // gpio, 2, 3, 9
  localparam logic [9:0] LEGAL_PA2  = 10'h21f; // gpio, 1, 2, 3, 4, 9
  localparam logic [9:0] LEGAL_PA5  = 10'h27d; // gpio, 2, 3, 4, 5, 6, 9
  localparam logic [9:0] LEGAL_PA8  = 10'h011; // gpio, 4
  localparam logic [9:0] LEGAL_PA11 = 10'h015; // gpio, 2, 4
  localparam logic [9:0] LEGAL_PA12 = 10'h1e9; // gpio, 3, 5, 6, 7, 8
  localparam logic [9:0] LEGAL_PA13 = 10'h1e9; // gpio, 3, 5, 6, 7, 8
  localparam logic [9:0] LEGAL_PA14 = 10'h361; // gpio, 5, 6, 8, 9
  localparam logic [9:0] LEGAL_PA15 = 10'h16d; // gpio, 2, 3, 5, 6, 8
  // port b
  localparam logic [9:0] LEGAL_PB5  = 10'h0c1; // gpio, 6, 7
  localparam logic [9:0] LEGAL_PB6  = 10'h1c3; // gpio, 1, 6, 7, 8
  localparam logic [9:0] LEGAL_PB7  = 10'h191; // gpio, 4, 7, 8

  // codes of the decoded pins, position inside their register word
  // other pins need no decode
  // port a low word
  wire scm_func_t pa1_code  = pin_code(port_a_low_pin_function, 1);
  wire scm_func_t pa2_code  = pin_code(port_a_low_pin_function, 2);
  wire scm_func_t pa5_code  = pin_code(port_a_low_pin_function, 5);
  // port a high word
  wire scm_func_t pa8_code  = pin_code(port_a_high_pin_function, 0);
  wire scm_func_t pa11_code = pin_code(port_a_high_pin_function, 3);
  wire scm_func_t pa12_code = pin_code(port_a_high_pin_function, 4);
  wire scm_func_t pa13_code = pin_code(port_a_high_pin_function, 5);
  wire scm_func_t pa14_code = pin_code(port_a_high_pin_function, 6);
  wire scm_func_t pa15_code = pin_code(port_a_high_pin_function, 7);
  // port b low word
  wire scm_func_t pb5_code  = pin_code(port_b_low_pin_function, 5);
  wire scm_func_t pb6_code  = pin_code(port_b_low_pin_function, 6);
  wire scm_func_t pb7_code  = pin_code(port_b_low_pin_function, 7);

  // one-hot selects
  // each falls back to gpio alone
  // port a
  wire logic [9:0] next_pa1  = sel_decode(pa1_code, LEGAL_PA1);
  wire logic [9:0] next_pa2  = sel_decode(pa2_code, LEGAL_PA2);
  wire logic [9:0] next_pa5  = sel_decode(pa5_code, LEGAL_PA5);
  wire logic [9:0] next_pa8  = sel_decode(pa8_code, LEGAL_PA8);
  wire logic [9:0] next_pa11 = sel_decode(pa11_code, LEGAL_PA11);
  wire logic [9:0] next_pa12 = sel_decode(pa12_code, LEGAL_PA12);
  wire logic [9:0] next_pa13 = sel_decode(pa13_code, LEGAL_PA13);
  wire logic [9:0] next_pa14 = sel_decode(pa14_code, LEGAL_PA14);
  wire logic [9:0] next_pa15 = sel_decode(pa15_code, LEGAL_PA15);
  // port b
  wire logic [9:0] next_pb5  = sel_decode(pb5_code, LEGAL_PB5);
  wire logic [9:0] next_pb6  = sel_decode(pb6_code, LEGAL_PB6);
  wire logic [9:0] next_pb7  = sel_decode(pb7_code, LEGAL_PB7);

  // transmit pins that may be modulated by the pulse width output
  // only code seven is transmit
  // mixing is in the serial port
  wire logic next_tx0_mod = next_pa12[`SCM_FN_7];
  wire logic next_tx1_mod = next_pb6[`SCM_FN_7];

  // select outputs registered; reset value means gpio on every pin
  // glitch free pad controls
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      // gpio everywhere
      pa1_select_o  <= 10'h001;
      pa2_select_o  <= 10'h001;
      pa5_select_o  <= 10'h001;
      pa8_select_o  <= 10'h001;
      pa11_select_o <= 10'h001;
      pa12_select_o <= 10'h001;
      pa13_select_o <= 10'h001;
      pa14_select_o <= 10'h001;
      pa15_select_o <= 10'h001;
      pb5_select_o  <= 10'h001;
      pb6_select_o  <= 10'h001;
      pb7_select_o  <= 10'h001;
    end else begin
      // decoded selects
      pa1_select_o  <= next_pa1;
      pa2_select_o  <= next_pa2;
      pa5_select_o  <= next_pa5;
      pa8_select_o  <= next_pa8;
      pa11_select_o <= next_pa11;
      pa12_select_o <= next_pa12;
      pa13_select_o <= next_pa13;
      pa14_select_o <= next_pa14;
      pa15_select_o <= next_pa15;
      pb5_select_o  <= next_pb5;
      pb6_select_o  <= next_pb6;
      pb7_select_o  <= next_pb7;
    end
  end

  // raw code buses and modulation flags
  // codes stay until rewritten
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      // all codes zero
      port_a_function_o     <= 64'h0;
      port_b_function_o     <= 32'h0;
      serial0_tx_modulate_o <= 1'b0;
      serial1_tx_modulate_o <= 1'b0;
    end else begin
      // mirror stored codes
      port_a_function_o     <= {port_a_high_pin_function, port_a_low_pin_function};
      port_b_function_o     <= port_b_low_pin_function;
      serial0_tx_modulate_o <= next_tx0_mod;
      serial1_tx_modulate_o <= next_tx1_mod;
    end
  end

endmodule

// File: verif/scm_sys_ctrl_checker.sv
// Purpose: concurrent checks on the ports of the system-control block
// Assumes: one clock, synchronous active-high reset
// Notes:   register outputs lag the write edge by one more edge
`timescale 1ns/1ps
module scm_sys_ctrl_checker #(
  parameter int PORT_A_PINS = 16,  // pins of port a
  parameter int PORT_B_PINS = 8    // pins of port b
) (
  input wire logic               clock_i,
  input wire logic               rst_i,
  input wire scm_pkg::scm_addr_t addr_i,
  input wire scm_pkg::scm_word_t wdata_i,
  input wire logic               wr_i,
  input wire logic               rd_i,
  input wire logic [31:0]        rdata_o,
  input wire logic               card_if1_block_reset_o,
  input wire logic               card_if0_block_reset_o,
  input wire logic               adc_block_reset_o,
  input wire logic               segment_display_block_reset_o,
  input wire logic               comparator_block_reset_o,
  input wire logic               pulse_width_block_reset_o,
  input wire logic               serial_port1_block_reset_o,
  input wire logic               serial_port0_block_reset_o,
  input wire logic               sync_serial1_block_reset_o,
  input wire logic               sync_serial0_block_reset_o,
  input wire logic               two_wire1_block_reset_o,
  input wire logic               two_wire0_block_reset_o,
  input wire logic [3:0]         timer_block_reset_o,
  input wire logic               gpio_block_reset_o,
  input wire logic               temp_sensor_enable_o,
  input wire logic [63:0]        port_a_function_o,
  input wire logic [9:0]         pa8_select_o,
  input wire logic               serial0_tx_modulate_o
);
  import scm_pkg::*;
  // ************************************************************
  // write decodes seen at the port
  // ************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire blk_wr  = wr_i && addr_i == 8'h0c;  // block reset write
  wire temp_wr = wr_i && addr_i == 8'h20;  // temperature control write
  property p_card;
    blk_wr |-> ##2 {card_if1_block_reset_o, card_if0_block_reset_o} == $past(wdata_i[31:30], 2);
  endproperty
  a_card: assert property (p_card) else $error("card reset mismatch");
  property p_adc_seg;
    blk_wr |-> ##2 {adc_block_reset_o, segment_display_block_reset_o} ==
      {$past(wdata_i[28], 2), $past(wdata_i[26], 2)};
  endproperty
  a_adc_seg: assert property (p_adc_seg) else $error("adc or segment reset mismatch");
  property p_cmp_pwm;
    blk_wr |-> ##2 {comparator_block_reset_o, pulse_width_block_reset_o} ==
      {$past(wdata_i[22], 2), $past(wdata_i[20], 2)};
  endproperty
  a_cmp_pwm: assert property (p_cmp_pwm) else $error("comparator or pwm reset mismatch");
  property p_serial;
    blk_wr |-> ##2 {serial_port1_block_reset_o, serial_port0_block_reset_o} == $past(wdata_i[17:16], 2);
  endproperty
  a_serial: assert property (p_serial) else $error("serial reset mismatch");
  property p_sync;
    blk_wr |-> ##2 {sync_serial1_block_reset_o, sync_serial0_block_reset_o} == $past(wdata_i[13:12], 2);
  endproperty
  a_sync: assert property (p_sync) else $error("sync serial reset mismatch");
  property p_two_wire;
    blk_wr |-> ##2 {two_wire1_block_reset_o, two_wire0_block_reset_o} == $past(wdata_i[9:8], 2);
  endproperty
  a_two_wire: assert property (p_two_wire) else $error("two wire reset mismatch");
  property p_timer_gpio;
    blk_wr |-> ##2 {timer_block_reset_o, gpio_block_reset_o} == $past(wdata_i[5:1], 2);
  endproperty
  a_timer_gpio: assert property (p_timer_gpio) else $error("timer or gpio reset mismatch");
  property p_temp;
    temp_wr |-> ##2 temp_sensor_enable_o == $past(wdata_i[0], 2);
  endproperty
  a_temp: assert property (p_temp) else $error("sensor enable mismatch");
  property p_unmapped;
    rd_i && addr_i == 8'h24 |=> rdata_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_modulate;
    serial0_tx_modulate_o == (port_a_function_o[51:48] == 4'h7);
  endproperty
  a_modulate: assert property (p_modulate) else $error("modulate flag mismatch");
  property p_pin8;
    port_a_function_o[35:32] == 4'h4 |-> pa8_select_o == 10'h010;
  endproperty
  a_pin8: assert property (p_pin8) else $error("pin a8 select mismatch");
  cover property (blk_wr);
  cover property (temp_wr);
  cover property (serial0_tx_modulate_o);
endmodule

bind scm_sys_ctrl scm_sys_ctrl_checker #(.PORT_A_PINS(PORT_A_PINS), .PORT_B_PINS(PORT_B_PINS))
  u_chk (.*);

// File: verif/tb.sv
// Purpose: self-checking bench for the system-control block
// Assumes: register port with one-cycle strobes, read data one cycle later
// Notes:   every code 0..f is written to every pin
`timescale 1ns/1ps
module tb;
  import scm_pkg::*;
  // ************************************************************
  // stimulus and observed signals
  // ************************************************************
  logic clock_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  scm_addr_t addr_i = 8'h00;
  scm_word_t wdata_i = 32'h0;
  logic [31:0] rdata_o, port_b_function_o;
  logic [63:0] port_a_function_o;
  logic [3:0] timer_block_reset_o;
  logic card_if1_block_reset_o, card_if0_block_reset_o, adc_block_reset_o;
  logic segment_display_block_reset_o, comparator_block_reset_o, pulse_width_block_reset_o;
  logic serial_port1_block_reset_o, serial_port0_block_reset_o, sync_serial1_block_reset_o;
  logic sync_serial0_block_reset_o, two_wire1_block_reset_o, two_wire0_block_reset_o;
  logic gpio_block_reset_o, temp_sensor_enable_o, serial0_tx_modulate_o, serial1_tx_modulate_o;
  logic [9:0] pa1_select_o, pa2_select_o, pa5_select_o, pa8_select_o, pa11_select_o;
  logic [9:0] pa12_select_o, pa13_select_o, pa14_select_o, pa15_select_o;
  logic [9:0] pb5_select_o, pb6_select_o, pb7_select_o;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  // legal code masks, pa1 first, pb7 last
  localparam logic [191:0] LEGAL = {16'h020d, 16'h021f, 16'h027d, 16'h0011, 16'h0015,
    16'h01e9, 16'h01e9, 16'h0361, 16'h016d, 16'h00c1, 16'h01c3, 16'h0191};
  localparam int POS [17] = '{31, 30, 28, 26, 22, 20, 17, 16, 13, 12, 9, 8, 5, 4, 3, 2, 1};
  wire [16:0] blk_rst = {card_if1_block_reset_o, card_if0_block_reset_o, adc_block_reset_o,
    segment_display_block_reset_o, comparator_block_reset_o, pulse_width_block_reset_o,
    serial_port1_block_reset_o, serial_port0_block_reset_o, sync_serial1_block_reset_o,
    sync_serial0_block_reset_o, two_wire1_block_reset_o, two_wire0_block_reset_o,
    timer_block_reset_o, gpio_block_reset_o};
  wire [119:0] sel_all = {pa1_select_o, pa2_select_o, pa5_select_o, pa8_select_o,
    pa11_select_o, pa12_select_o, pa13_select_o, pa14_select_o, pa15_select_o,
    pb5_select_o, pb6_select_o, pb7_select_o};
  always #5 clock_i = ~clock_i;
  scm_sys_ctrl u_dut (.*);
  // ************************************************************
  // bus and compare tasks
  // ************************************************************
  task automatic check_val(input logic [127:0] got, input logic [127:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus_write(input scm_addr_t a, input scm_word_t d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic read_check(input scm_addr_t a, input scm_word_t exp);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 check_val(rdata_o, exp);
  endtask
  // outputs follow one edge after the write edge
  task automatic settle;
    @(posedge clock_i);
    #1;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset_values;
    for (int i = 0; i < 5; i++) begin
      read_check(i == 0 ? 8'h0c : 8'h20 + 8'(i == 1 ? 0 : 8 + 4 * i), 32'h0);
    end
    check_val(blk_rst, 17'h0);
    check_val(temp_sensor_enable_o, 1'b0);
    check_val(sel_all, {12{10'h001}});
  endtask
  task automatic t_block_reset;
    for (int i = 0; i < 17; i++) begin
      bus_write(8'h0c, 32'h1 << POS[i]);
      settle();
      check_val(blk_rst, 17'h1 << (16 - i));
    end
    bus_write(8'h0c, 32'hffff_ffff);
    read_check(8'h0c, 32'hd453_333e);
    repeat (8) @(posedge clock_i);
    check_val(blk_rst, 17'h1_ffff);
    bus_write(8'h0c, 32'h0);
    settle();
    check_val(blk_rst, 17'h0);
  endtask
  task automatic t_temp;
    bus_write(8'h20, 32'hffff_ffff);
    read_check(8'h20, 32'h1);
    check_val(temp_sensor_enable_o, 1'b1);
    bus_write(8'h20, 32'h0);
    settle();
    check_val(temp_sensor_enable_o, 1'b0);
  endtask
  task automatic t_pins;
    scm_word_t w;
    for (int k = 0; k < 16; k++) begin
      w = {8{4'(k)}};
      bus_write(8'h30, w);
      bus_write(8'h34, w);
      bus_write(8'h38, w);
      settle();
      for (int p = 0; p < 12; p++) begin
        check_val(sel_all[p*10+:10], LEGAL[p*16+k] ? 10'(1 << k) : 10'h001);
      end
      check_val({port_a_function_o, port_b_function_o}, {w, w, w});
      check_val({serial0_tx_modulate_o, serial1_tx_modulate_o}, {2{k == 7}});
      read_check(8'h34, w);
    end
  endtask
  task automatic t_unmapped;
    bus_write(8'h24, 32'hffff_ffff);
    bus_write(8'h3c, 32'hffff_ffff);
    read_check(8'h24, 32'h0);
    read_check(8'h3c, 32'h0);
    read_check(8'h0c, 32'h0);
    read_check(8'h38, 32'hffff_ffff);
  endtask
  // ************************************************************
  // closing report and run control
  // ************************************************************
  task automatic wrap_up;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard, far above the expected run length
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_block_reset();
    t_temp();
    t_pins();
    t_unmapped();
    wrap_up();
  end
endmodule
